// *** core/ssc_pkg.sv ***
// shared constants and types for the simultaneous sample conversion link
// Notes on behaviour
// [RULE_01] span pin high gives 10 V, low 5 V
// [RULE_02] host waits 80 us after span change
// [RULE_03] host resets device after power-up; the host drives no reset, both ends take reset_n from the interface
// [RULE_04] trigger rising edge holds all eight channels
// [RULE_05] internal clock times conversion, 4 us total
// [RULE_06] busy falls only after all eight conversions
// [RULE_07] busy fall returns channels to tracking
// [RULE_08] new results readable once busy is low
// [RULE_09] previous results readable while busy high
// [RULE_10] span pin kept fixed during operation
// [RULE_11] busy rises at trigger, holds until done
// [RULE_12] results coded in two's complement
// [RULE_13] triggers during busy are ignored
package ssc_pkg;
    // ==========================================
    // sizes
    localparam int SSC_CHANNELS = 8;
    localparam int SSC_RES_BITS = 18;
    localparam int SSC_CH_BITS = 3;
    // ==========================================
    // timing
    localparam int SSC_CLK_MHZ = 20;
    localparam int SSC_CONV_NS = 4000;
    localparam int SSC_CONV_CYC = (SSC_CONV_NS * SSC_CLK_MHZ) / 1000;
    localparam int SSC_CH_CYC = SSC_CONV_CYC / SSC_CHANNELS;
    localparam int SSC_SETTLE_US = 80;
    localparam int SSC_SETTLE_CYC = SSC_SETTLE_US * SSC_CLK_MHZ;
    localparam int SSC_CNT_BITS = 12;
    // ==========================================
    // span codes
    localparam logic SSC_SPAN_10V = 1'b1;
    localparam logic SSC_SPAN_5V = 1'b0;

    typedef logic signed [SSC_RES_BITS-1:0] ssc_sample_t;

    typedef enum logic [1:0] {
        SSC_IDLE = 2'b00,
        SSC_CONV = 2'b01,
        SSC_DONE = 2'b11
    } ssc_state_t;
endpackage

// *** core/ssc_if.sv ***
// interface joining the converter device and its host controller
`timescale 1ns/100ps
interface ssc_if
    import ssc_pkg::*;
(
    input wire logic ref_clk,
    input wire logic reset_n
);
    logic sample_trigger;
    logic span_select;
    logic busy;
    logic [SSC_CH_BITS-1:0] rd_channel;
    ssc_sample_t rd_data;

    modport device (
        input ref_clk,
        input reset_n,
        input sample_trigger,
        input span_select,
        input rd_channel,
        output busy,
        output rd_data
    );

    modport host (
        input ref_clk,
        input reset_n,
        output sample_trigger,
        output span_select,
        output rd_channel,
        input busy,
        input rd_data
    );
endinterface

// *** core/ssc_device.sv ***
// converter end: sample hold, timed conversion, result register
`timescale 1ns/100ps
module ssc_device
    import ssc_pkg::*;
#(
    parameter int CONV_CYC = SSC_CONV_CYC
)
(
    ssc_if.device link,
    input wire ssc_sample_t ana_in [SSC_CHANNELS],
    output logic hold,
    output logic span_10v
);
    // ==========================================
    // state
    ssc_state_t state_ff, nxt_state;
    logic trig_d_ff, nxt_trig_d;
    logic [SSC_CNT_BITS-1:0] cnt_ff, nxt_cnt;
    logic [SSC_CH_BITS-1:0] ch_ff, nxt_ch;
    logic span_ff, nxt_span;
    ssc_sample_t held_ff [SSC_CHANNELS];
    ssc_sample_t res_ff [SSC_CHANNELS];
    ssc_sample_t work_ff [SSC_CHANNELS];
    ssc_sample_t rd_ff;
    logic rise;
    logic ch_last;

    assign rise = link.sample_trigger & ~trig_d_ff;
    assign ch_last = (cnt_ff == SSC_CNT_BITS'(CONV_CYC / SSC_CHANNELS - 1));

    always_comb
    begin
        nxt_state = state_ff;
        nxt_trig_d = link.sample_trigger;
        nxt_cnt = cnt_ff;
        nxt_ch = ch_ff;
        nxt_span = link.span_select; // RULE_01
        case (state_ff)
            SSC_IDLE:
            begin
                if (rise)
                begin
                    nxt_state = SSC_CONV; // RULE_11
                    nxt_cnt = '0;
                    nxt_ch = '0;
                end
            end
            SSC_CONV:
            begin
                // further edges fall through here untouched
                if (ch_last) // RULE_13
                begin
                    nxt_cnt = '0;
                    nxt_ch = ch_ff + 1'b1;
                    if (ch_ff == SSC_CH_BITS'(SSC_CHANNELS - 1))
                        nxt_state = SSC_DONE; // RULE_06
                end
                else
                    nxt_cnt = cnt_ff + 1'b1; // RULE_05
            end
            SSC_DONE: nxt_state = SSC_IDLE; // RULE_07
            default: nxt_state = SSC_IDLE;
        endcase
    end

    always_ff @(posedge link.ref_clk or negedge link.reset_n)
    begin
        if (!link.reset_n)
        begin
            state_ff <= SSC_IDLE;
            trig_d_ff <= 1'b0;
            cnt_ff <= '0;
            ch_ff <= '0;
            span_ff <= SSC_SPAN_5V;
        end
        else
        begin
            state_ff <= nxt_state;
            trig_d_ff <= nxt_trig_d;
            cnt_ff <= nxt_cnt;
            ch_ff <= nxt_ch;
            span_ff <= nxt_span;
        end
    end

    // ==========================================
    // sample, convert, publish
    // results stay put until the whole set is done, so reads mid-conversion see old data
    genvar gi;
    generate
        for (gi = 0; gi < SSC_CHANNELS; gi++)
        begin : g_ch
            always_ff @(posedge link.ref_clk or negedge link.reset_n)
            begin
                if (!link.reset_n)
                begin
                    held_ff[gi] <= '0;
                    work_ff[gi] <= '0;
                    res_ff[gi] <= '0;
                end
                else
                begin
                    if (state_ff == SSC_IDLE && rise)
                        held_ff[gi] <= ana_in[gi]; // RULE_04
                    if (state_ff == SSC_CONV && ch_last && ch_ff == SSC_CH_BITS'(gi))
                        work_ff[gi] <= held_ff[gi]; // RULE_12
                    if (state_ff == SSC_CONV && ch_last && ch_ff == SSC_CH_BITS'(SSC_CHANNELS - 1))
                        res_ff[gi] <= (gi == SSC_CHANNELS - 1) ? held_ff[gi] : work_ff[gi]; // RULE_08 RULE_09
                end
            end
        end
    endgenerate

    always_ff @(posedge link.ref_clk or negedge link.reset_n)
    begin
        if (!link.reset_n)
            rd_ff <= '0;
        else
            rd_ff <= res_ff[link.rd_channel]; // RULE_09
    end

    assign link.busy = (state_ff == SSC_CONV); // RULE_11
    assign link.rd_data = rd_ff;
    assign hold = (state_ff == SSC_CONV); // RULE_04 RULE_07
    assign span_10v = span_ff; // RULE_01
endmodule

// *** core/ssc_host.sv ***
// host end: reset-aware settle wait, trigger, read back all channels
`timescale 1ns/100ps
module ssc_host
    import ssc_pkg::*;
#(
    parameter int SETTLE_CYC = SSC_SETTLE_CYC
)
(
    ssc_if.host link,
    input wire logic start,
    input wire logic span_req,
    output logic [SSC_CH_BITS-1:0] res_channel,
    output ssc_sample_t res_data,
    output logic res_valid,
    output logic ready
);
    typedef enum logic [2:0] {
        SSC_H_SETTLE = 3'b000,
        SSC_H_IDLE = 3'b001,
        SSC_H_TRIG = 3'b011,
        SSC_H_WAIT = 3'b010,
        SSC_H_READ = 3'b110
    } ssc_hstate_t;

    ssc_hstate_t st_ff, nxt_st;
    logic [SSC_CNT_BITS-1:0] cnt_ff, nxt_cnt;
    logic span_ff, nxt_span;
    logic [SSC_CH_BITS-1:0] ch_ff, nxt_ch;
    logic [SSC_CH_BITS-1:0] rch_ff, nxt_rch;
    logic vld_ff, nxt_vld;
    ssc_sample_t dat_ff, nxt_dat;

    always_comb
    begin
        nxt_st = st_ff;
        nxt_cnt = cnt_ff;
        nxt_span = span_ff;
        nxt_ch = ch_ff;
        nxt_rch = rch_ff;
        nxt_vld = 1'b0;
        nxt_dat = dat_ff;
        case (st_ff)
            SSC_H_SETTLE:
            begin
                if (cnt_ff == SSC_CNT_BITS'(SETTLE_CYC - 1))
                    nxt_st = SSC_H_IDLE; // RULE_02
                else
                    nxt_cnt = cnt_ff + 1'b1;
            end
            SSC_H_IDLE:
            begin
                // span only moves when asked; hardwiring is the usual use
                if (span_req != span_ff) // RULE_10
                begin
                    nxt_span = span_req;
                    nxt_cnt = '0;
                    nxt_st = SSC_H_SETTLE; // RULE_02
                end
                else if (start)
                    nxt_st = SSC_H_TRIG;
            end
            SSC_H_TRIG: nxt_st = SSC_H_WAIT; // RULE_11
            SSC_H_WAIT:
            begin
                if (!link.busy)
                begin
                    nxt_ch = '0;
                    nxt_cnt = '0;
                    nxt_st = SSC_H_READ; // RULE_08
                end
            end
            SSC_H_READ:
            begin
                // rd_data lags rd_channel by one cycle, so step n hands over channel n-1
                if (cnt_ff != '0)
                begin
                    nxt_vld = 1'b1;
                    nxt_dat = link.rd_data;
                    nxt_rch = SSC_CH_BITS'(cnt_ff - 1'b1);
                end
                if (cnt_ff == SSC_CNT_BITS'(SSC_CHANNELS))
                    nxt_st = SSC_H_IDLE;
                else
                begin
                    nxt_cnt = cnt_ff + 1'b1;
                    nxt_ch = ch_ff + 1'b1;
                end
            end
            default: nxt_st = SSC_H_IDLE;
        endcase
    end

    always_ff @(posedge link.ref_clk or negedge link.reset_n)
    begin
        if (!link.reset_n)
        begin
            st_ff <= SSC_H_SETTLE; // RULE_03
            cnt_ff <= '0;
            span_ff <= SSC_SPAN_10V;
            ch_ff <= '0;
            rch_ff <= '0;
            vld_ff <= 1'b0;
            dat_ff <= '0;
        end
        else
        begin
            st_ff <= nxt_st;
            cnt_ff <= nxt_cnt;
            span_ff <= nxt_span;
            ch_ff <= nxt_ch;
            rch_ff <= nxt_rch;
            vld_ff <= nxt_vld;
            dat_ff <= nxt_dat;
        end
    end

    assign link.sample_trigger = (st_ff == SSC_H_TRIG) || (st_ff == SSC_H_WAIT && link.busy);
    assign link.span_select = span_ff; // RULE_01
    assign link.rd_channel = ch_ff;
    assign res_channel = rch_ff;
    assign res_data = dat_ff;
    assign res_valid = vld_ff;
    // a pending span change leaves idle to settle, so a start then would be lost
    assign ready = (st_ff == SSC_H_IDLE) && (span_req == span_ff);
endmodule

// *** tb/ssc_props.sv ***
// checker for the trigger, busy and settle handshake
`timescale 1ns/100ps
module ssc_props
    import ssc_pkg::*;
#(
    parameter int CONV_CYC = SSC_CONV_CYC,
    parameter int SETTLE_CYC = SSC_SETTLE_CYC
)
(
    input wire logic ref_clk,
    input wire logic reset_n,
    input wire logic sample_trigger,
    input wire logic span_select,
    input wire logic busy,
    input wire logic [SSC_CH_BITS-1:0] rd_channel,
    input wire ssc_sample_t rd_data
);
    // ==========
    // helper counters
    logic [SSC_CNT_BITS-1:0] busy_cnt_ff, nxt_busy_cnt, calm_cnt_ff, nxt_calm_cnt;
    logic span_d_ff;
    always_comb
    begin
        nxt_busy_cnt = busy ? busy_cnt_ff + 1'b1 : '0;
        nxt_calm_cnt = (span_select != span_d_ff) ? '0 : calm_cnt_ff + (calm_cnt_ff < SETTLE_CYC);
    end
    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            busy_cnt_ff <= '0;
            calm_cnt_ff <= '0;
            span_d_ff <= SSC_SPAN_10V;
        end
        else
        begin
            busy_cnt_ff <= nxt_busy_cnt;
            calm_cnt_ff <= nxt_calm_cnt;
            span_d_ff <= span_select;
        end
    end
    // ==========
    // properties
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!reset_n);
    sequence s_taken; $rose(sample_trigger) && !busy; endsequence
    sequence s_end; $fell(busy); endsequence
    property p_trig_start; s_taken |=> busy; endproperty
    property p_conv_len; s_end |-> busy_cnt_ff == CONV_CYC; endproperty
    property p_no_late; busy |-> busy_cnt_ff < CONV_CYC; endproperty
    property p_busy_trig; busy |-> sample_trigger; endproperty
    property p_quiet; !busy && !sample_trigger |=> !busy; endproperty
    property p_track; s_end |-> !busy [*2]; endproperty
    property p_prev_data; busy && $stable(rd_channel) |=> !busy || $stable(rd_data); endproperty
    // two cycles of slack for the host's ready, which is decoded from its state and not registered
    property p_settle; $rose(sample_trigger) |-> calm_cnt_ff >= SETTLE_CYC - 2; endproperty
    a_trig_start: assert property (p_trig_start)
        else $error("busy missed the trigger");
    a_conv_len: assert property (p_conv_len)
        else $error("conversion length wrong");
    a_no_late: assert property (p_no_late)
        else $error("busy held too long");
    a_busy_trig: assert property (p_busy_trig)
        else $error("trigger dropped while busy");
    a_quiet: assert property (p_quiet)
        else $error("busy rose without trigger");
    a_track: assert property (p_track)
        else $error("no idle gap after busy fall");
    a_prev_data: assert property (p_prev_data)
        else $error("old results disturbed while busy");
    a_settle: assert property (p_settle)
        else $error("trigger before settling");
endmodule

// *** tb/tb_top.sv ***
// self-checking bench joining device and host ends
`timescale 1ns/100ps
module tb_top
    import ssc_pkg::*;
;
    localparam int CONV = 16;
    localparam int SETTLE = 4;
    logic ref_clk, reset_n, start, span_req, hold, span_10v, res_valid, ready;
    logic [SSC_CH_BITS-1:0] res_channel, exp_ch;
    ssc_sample_t ana_in [SSC_CHANNELS];
    ssc_sample_t res_data;
    ssc_sample_t exp_q [$];
    int error_cnt, checks;
    ssc_if i_ssc_if (.ref_clk(ref_clk), .reset_n(reset_n));
    ssc_device #(.CONV_CYC(CONV)) i_ssc_device (.link(i_ssc_if), .ana_in(ana_in), .hold(hold), .span_10v(span_10v));
    ssc_host #(.SETTLE_CYC(SETTLE)) i_ssc_host (.link(i_ssc_if), .start(start), .span_req(span_req),
        .res_channel(res_channel), .res_data(res_data), .res_valid(res_valid), .ready(ready));
    ssc_props #(.CONV_CYC(CONV), .SETTLE_CYC(SETTLE)) i_ssc_props (.ref_clk(ref_clk), .reset_n(reset_n),
        .sample_trigger(i_ssc_if.sample_trigger), .span_select(i_ssc_if.span_select), .busy(i_ssc_if.busy),
        .rd_channel(i_ssc_if.rd_channel), .rd_data(i_ssc_if.rd_data));
    // ==========
    // tasks
    task automatic check(input string what, input logic [SSC_RES_BITS-1:0] exp, input logic [SSC_RES_BITS-1:0] got);
        checks++;
        if (exp !== got)
        begin
            error_cnt++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic results();
        $display("checks %0d mismatches %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    task automatic wait_ready(input logic val);
        int n;
        n = 0;
        while (ready !== val && n < 400)
        begin
            @(posedge ref_clk);
            n++;
        end
        check("ready", {17'h0, val}, {17'h0, ready});
    endtask
    // corner mode puts positive full-scale codes on even channels and negative full-scale codes on odd ones
    task automatic convert(input bit corner, input string name);
        logic [31:0] v;
        wait_ready(1'b1);
        for (int i = 0; i < SSC_CHANNELS; i++)
        begin
            v = corner ? (i[0] ? 32'h20000 : 32'h1ffff) : $urandom;
            ana_in[i] <= v[SSC_RES_BITS-1:0];
            exp_q.push_back(v[SSC_RES_BITS-1:0]);
        end
        start <= 1'b1;
        wait_ready(1'b0);
        start <= 1'b0;
        $display("test %s done", name);
    endtask
    // ==========
    // result monitor
    always @(posedge ref_clk)
    begin
        check("hold", {17'h0, i_ssc_if.busy}, {17'h0, hold});
        if (res_valid === 1'b1)
        begin
            if (exp_q.size() == 0)
                check("spare result", 18'h0, 18'h1);
            else
                check("result", exp_q.pop_front(), res_data);
            check("channel", {15'h0, exp_ch}, {15'h0, res_channel});
            exp_ch = exp_ch + 1'b1;
        end
    end
    // ==========
    // stimulus
    initial
    begin
        ref_clk = 1'b0;
        forever #25 ref_clk = ~ref_clk;
    end
    initial
    begin
        #(50 * 5000);
        error_cnt++;
        results();
    end
    initial
    begin
        reset_n = 1'b0;
        start = 1'b0;
        span_req = SSC_SPAN_10V;
        exp_ch = '0;
        foreach (ana_in[i])
            ana_in[i] = '0;
        void'($urandom(32'h5b6c));
        repeat (3) @(posedge ref_clk);
        reset_n <= 1'b1;
        convert(1'b1, "corners");
        repeat (3) convert(1'b0, "random");
        for (int s = 0; s < 2; s++)
        begin
            span_req <= s[0];
            convert(1'b0, "span");
            check("span", {17'h0, s[0]}, {17'h0, span_10v});
        end
        wait_ready(1'b1);
        // the last result shows in the edge where ready rises; let the monitor take it first
        repeat (2) @(posedge ref_clk);
        check("queue", 18'h0, 18'(exp_q.size()));
        results();
    end
endmodule
